// file: hw/dma_channel_alternation.sv
// Purpose: channel 1 address registers, request steering, channel
//   alternation and channel 0 mode and bus timing decode
// Assumes: one clock, synchronous active-low reset, axi4-lite slave
// Notes: byte counters live elsewhere; their zero events come in as pulses
//
// How it works
// - channel 1 memory address holds twenty bits
// - io address low and high bytes stored
// - top io byte selects request, alternation bits
// - channel 0 end sets current bit
// - channel 1 end clears current bit
// - current bit ignored while alternation disabled
// - current zero withholds channel 1 request
// - current one withholds channel 0 request, in io pacing only
// - current bit writable at any time; end events win in the same cycle
// - io source select: pin, serial rx full
// - io destination select: pin, serial tx empty
// - io to io mode combinations reserved
// - mode field: increment, decrement, fixed mem, fixed io
// - fixed memory mode uses ordinary memory cycles
// - memory mode bit picks burst or steal
// - burst holds bus until count zero
// - cycle steal gives cpu one cycle between
// - io channel 0 paced by request, ignores timing
// - reset clears timing bit to cycle steal
`timescale 1ns/1ps
`default_nettype none
module dma_channel_alternation
  import dma_alt_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request sources
  input wire logic ext_request_ch0,
  input wire logic ext_request_ch1,
  input wire logic serial_rx_full_0,
  input wire logic serial_rx_full_1,
  input wire logic serial_tx_empty_0,
  input wire logic serial_tx_empty_1,
  // channel 0 request picked by its high address bits, from the engine
  input wire logic ch0_selected_request,
  // byte count zero events from the transfer engine
  input wire logic ch0_end,
  input wire logic ch1_end,
  // transfer engine side: one pulse per byte moved on channel 0
  input wire logic ch0_byte_done,
  // request and timing outputs
  output logic ch0_request,
  output logic ch1_request,
  output logic ch0_bus_hold,
  output logic ch0_cpu_slot,
  // channel 0 address step decode
  output logic [1:0] ch0_src_step,
  output logic [1:0] ch0_dest_step,
  output logic ch0_mode_reserved,
  output logic ch0_is_io,
  // channel 1 addresses
  output logic [19:0] ch1_mem_address,
  output logic [15:0] ch1_io_address
);

  // ==========================================================
  // registers
  logic [7:0] ch1_mem_addr_low;
  logic [7:0] ch1_mem_addr_high;
  logic [BANK_BITS-1:0] ch1_mem_addr_bank;
  logic [7:0] ch1_io_addr_low;
  logic [7:0] ch1_io_addr_high;
  logic alternation_enable;
  logic alternation_current;
  logic [2:0] ch1_request_select;
  logic [7:0] dma_control_reg;
  logic steal_gap;

  // ==========================================================
  // bus write channel
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic [7:0] wr_index;
  logic wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_index = aw_addr[9:2];
  assign wr_ok = (aw_addr[ADDR_WIDTH-1:10] == '0) && (aw_addr[1:0] == 2'h0)
    && ((wr_index >= IDX_MEM_LOW && wr_index <= IDX_REQ_ALT)
    || wr_index == IDX_CH0_MODE);

  // address and data captured independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // response one cycle after both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  logic wr_en;
  assign wr_en = do_write && wr_ok && w_strb[0];

  // ==========================================================
  // channel 0 mode register; a channel 0 end drops its enable so that
  // burst or steal timing stops asking for the bus once the count is
  // spent; a software write in the same cycle wins, being fresh
  // programming that replaces the transfer which just ended
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_control_reg <= RESET_MODE;
    else if (wr_en && (wr_index == IDX_CH0_MODE))
      dma_control_reg <= w_data[7:0];
    else if (ch0_end)
      dma_control_reg[CH0_EN_BIT] <= 1'b0;
  end

  // ==========================================================
  // register file; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch1_mem_addr_low <= RESET_BYTE;
      ch1_mem_addr_high <= RESET_BYTE;
      ch1_mem_addr_bank <= '0;
      ch1_io_addr_low <= RESET_BYTE;
      ch1_io_addr_high <= RESET_BYTE;
      ch1_request_select <= SEL_EXT;
      alternation_enable <= 1'b0;
    end
    else if (wr_en)
    begin
      case (wr_index)
        IDX_MEM_LOW: ch1_mem_addr_low <= w_data[7:0];
        IDX_MEM_HIGH: ch1_mem_addr_high <= w_data[7:0];
        IDX_MEM_BANK: ch1_mem_addr_bank <= w_data[BANK_BITS-1:0];
        IDX_IO_LOW: ch1_io_addr_low <= w_data[7:0];
        IDX_IO_HIGH: ch1_io_addr_high <= w_data[7:0];
        IDX_REQ_ALT:
        begin
          alternation_enable <= w_data[ALT_ENABLE_BIT];
          ch1_request_select <= w_data[2:0];
        end
        // the channel 0 mode register has its own process above
        default: ch1_mem_addr_low <= ch1_mem_addr_low;
      endcase
    end
  end

  // ==========================================================
  // alternation current bit: hardware end events win over a software
  // write in the same cycle so that no channel end is lost
  logic sw_alt_write;
  assign sw_alt_write = wr_en && (wr_index == IDX_REQ_ALT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alternation_current <= 1'b0;
    else if (alternation_enable && ch0_end)
      alternation_current <= 1'b1;
    else if (alternation_enable && ch1_end)
      alternation_current <= 1'b0;
    else if (sw_alt_write)
      alternation_current <= w_data[ALT_CURRENT_BIT];
  end

  // ==========================================================
  // bus read channel, answer one cycle after the address is taken
  // the read mux follows araddr live; the master holds it until taken
  logic [7:0] rd_index;
  logic [7:0] rd_byte;
  logic rd_ok;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_index = s_axi_araddr[9:2];

  always_comb
  begin
    rd_ok = (s_axi_araddr[ADDR_WIDTH-1:10] == '0)
      && (s_axi_araddr[1:0] == 2'h0);
    case (rd_index)
      IDX_MEM_LOW: rd_byte = ch1_mem_addr_low;
      IDX_MEM_HIGH: rd_byte = ch1_mem_addr_high;
      IDX_MEM_BANK: rd_byte = {{(8-BANK_BITS){1'b0}}, ch1_mem_addr_bank};
      IDX_IO_LOW: rd_byte = ch1_io_addr_low;
      IDX_IO_HIGH: rd_byte = ch1_io_addr_high;
      IDX_REQ_ALT: rd_byte = {alternation_enable, alternation_current,
        3'h0, ch1_request_select};
      IDX_CH0_MODE: rd_byte = dma_control_reg;
      IDX_STATUS: rd_byte = {3'h0, ch0_mode_reserved, ch0_bus_hold,
        ch0_request, ch1_request, alternation_current};
      default:
      begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // channel 1 request steering
  logic ch1_io_direction;
  logic ch1_raw;
  assign ch1_io_direction = dma_control_reg[CH1_DIR_BIT];

  always_comb
  begin
    case (ch1_request_select)
      SEL_EXT: ch1_raw = ext_request_ch1;
      SEL_SERIAL0: ch1_raw = ch1_io_direction ? serial_rx_full_0
        : serial_tx_empty_0;
      SEL_SERIAL1: ch1_raw = ch1_io_direction ? serial_rx_full_1
        : serial_tx_empty_1;
      default: ch1_raw = 1'b0;
    endcase
  end

  // alternation gating: the current bit only bites when enabled
  assign ch1_request = dma_control_reg[CH1_EN_BIT] && ch1_raw
    && !(alternation_enable && !alternation_current);

  // ==========================================================
  // channel 0 mode decode
  assign ch0_dest_step = dma_control_reg[DEST_MODE_LSB +: 2];
  assign ch0_src_step = dma_control_reg[SRC_MODE_LSB +: 2];
  // io-to-io and fixed memory paired with any fixed side are reserved
  assign ch0_mode_reserved = ch0_dest_step[1] && ch0_src_step[1];
  assign ch0_is_io = !ch0_mode_reserved
    && (ch0_dest_step == MODE_FIX_IO || ch0_src_step == MODE_FIX_IO);

  logic ch0_active;
  logic burst;
  assign ch0_active = dma_control_reg[CH0_EN_BIT] && !ch0_mode_reserved;
  assign burst = dma_control_reg[MEM_TIMING_BIT];

  // ==========================================================
  // cycle steal gap: after each byte the cpu gets one cycle
  // io pacing needs no gap, the requester sets the rate itself
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      steal_gap <= 1'b0;
    else
      steal_gap <= ch0_byte_done && !burst && !ch0_is_io;
  end

  // ==========================================================
  // channel 0 request and bus ownership
  always_comb
  begin
    // the end pulse lets the bus go in the cycle the count runs out
    if (!ch0_active || ch0_end)
    begin
      ch0_request = 1'b0;
      ch0_bus_hold = 1'b0;
    end
    else if (ch0_is_io)
    begin
      // io pacing ignores the timing bit
      ch0_request = ch0_selected_request
        && !(alternation_enable && alternation_current);
      ch0_bus_hold = ch0_request;
    end
    else if (burst)
    begin
      ch0_request = 1'b1;
      ch0_bus_hold = 1'b1;
    end
    else
    begin
      ch0_request = !steal_gap;
      ch0_bus_hold = !steal_gap;
    end
  end

  assign ch0_cpu_slot = ch0_active && !ch0_is_io && !burst && steal_gap;

  // ==========================================================
  // address outputs
  assign ch1_mem_address = {ch1_mem_addr_bank, ch1_mem_addr_high,
    ch1_mem_addr_low};
  assign ch1_io_address = {ch1_io_addr_high, ch1_io_addr_low};

endmodule : dma_channel_alternation
`default_nettype wire

// file: common/dma_alt_pkg.sv
// Purpose: shared constants for the dma channel mode and alternation block
// Assumes: 32-bit axi4-lite register bus, one register per aligned word
// Notes: printed offsets are not multiples of four, so they are indices
package dma_alt_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MEM_LOW = 8'h28;
  localparam logic [7:0] IDX_MEM_HIGH = 8'h29;
  localparam logic [7:0] IDX_MEM_BANK = 8'h2a;
  localparam logic [7:0] IDX_IO_LOW = 8'h2b;
  localparam logic [7:0] IDX_IO_HIGH = 8'h2c;
  localparam logic [7:0] IDX_REQ_ALT = 8'h2d;
  localparam logic [7:0] IDX_CH0_MODE = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  // ==========================================================
  // field positions
  localparam int ALT_ENABLE_BIT = 7;
  localparam int ALT_CURRENT_BIT = 6;
  localparam int MEM_TIMING_BIT = 1;
  localparam int BANK_BITS = 4;
  // channel 0 mode register: [7:6] dest mode, [5:4] src mode,
  // [3] ch0 enable, [2] ch1 enable, [1] timing, [0] ch1 io direction
  localparam int DEST_MODE_LSB = 6;
  localparam int SRC_MODE_LSB = 4;
  localparam int CH0_EN_BIT = 3;
  localparam int CH1_EN_BIT = 2;
  localparam int CH1_DIR_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_MODE = 8'h00;
  // ==========================================================
  // encodings
  localparam logic [1:0] MODE_INC = 2'h0;
  localparam logic [1:0] MODE_DEC = 2'h1;
  localparam logic [1:0] MODE_FIX_MEM = 2'h2;
  localparam logic [1:0] MODE_FIX_IO = 2'h3;
  localparam logic [2:0] SEL_EXT = 3'h0;
  localparam logic [2:0] SEL_SERIAL0 = 3'h1;
  localparam logic [2:0] SEL_SERIAL1 = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dma_alt_pkg

// file: verif/dma_alt_assertions.sv
// Purpose: port checks for the channel alternation block
// Assumes: one clock, synchronous active-low reset
// Notes: register contents are not visible from here
`timescale 1ns/1ps
`default_nettype none
module dma_alt_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // channel 0 decode and timing
  input wire logic ch0_end,
  input wire logic ch0_byte_done,
  input wire logic ch0_request,
  input wire logic ch0_bus_hold,
  input wire logic ch0_cpu_slot,
  input wire logic ch0_mode_reserved,
  input wire logic ch0_is_io,
  input wire logic [1:0] ch0_src_step,
  input wire logic [1:0] ch0_dest_step
);
  // ==========================================
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_rwait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_steal;
    ch0_byte_done ##1 ch0_cpu_slot;
  endsequence
  property p_bhold;
    s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold;
    s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_arblock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblock: assert property (p_arblock) else $error("read overlap");
  property p_resv;
    ch0_mode_reserved == (ch0_src_step[1] && ch0_dest_step[1]);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved flag");
  property p_resv_req;
    ch0_mode_reserved |-> !ch0_request && !ch0_bus_hold;
  endproperty
  a_resv_req: assert property (p_resv_req) else $error("bad mode");
  property p_slot;
    ch0_cpu_slot |-> !ch0_bus_hold && $past(ch0_byte_done);
  endproperty
  a_slot: assert property (p_slot) else $error("stray cpu slot");
  property p_io;
    !ch0_mode_reserved |->
      ch0_is_io == (ch0_src_step == 2'h3 || ch0_dest_step == 2'h3);
  endproperty
  a_io: assert property (p_io) else $error("io decode");
  property p_end;
    ch0_end && !ch0_is_io |=> !ch0_bus_hold;
  endproperty
  a_end: assert property (p_end) else $error("bus kept");
  c_steal: cover property (s_steal);
endmodule : dma_alt_assertions
bind dma_channel_alternation dma_alt_assertions u_chk (.aclk, .aresetn,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ch0_end, .ch0_byte_done,
  .ch0_request, .ch0_bus_hold, .ch0_cpu_slot, .ch0_mode_reserved,
  .ch0_is_io, .ch0_src_step, .ch0_dest_step);
`default_nettype wire

// file: verif/dma_peripheral_model.sv
// Purpose: requesting peripheral with the channel 0 byte counter
// Assumes: one byte per grant, never two grants back to back
// Notes: request drops only when the count is spent
`timescale 1ns/1ps
`default_nettype none
module dma_peripheral_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // count load and grant
  input wire logic load,
  input wire logic [7:0] count_in,
  input wire logic served,
  // request level and transfer events
  output logic request,
  output logic byte_done,
  output logic count_end
);
  logic [7:0] count;
  logic take;
  // one line feeds all three request pins of the block
  assign request = count != 8'h00;
  assign take = served && request && !byte_done && !load;
  // the settling cycle after a byte keeps grants one apart
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 8'h00;
      byte_done <= 1'b0;
      count_end <= 1'b0;
    end
    else
    begin
      byte_done <= take;
      count_end <= take && count == 8'h01;
      if (load)
        count <= count_in;
      else if (take)
        count <= count - 8'h01;
    end
  end
endmodule : dma_peripheral_model
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the channel alternation block
// Assumes: register index times four is the byte address
// Notes: the peripheral model drives all three request pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dma_alt_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, dreq, load, ch1_end;
  logic ch0_end, ch0_byte_done, ch0_request, ch1_request, ch0_bus_hold;
  logic ch0_cpu_slot, ch0_mode_reserved, ch0_is_io;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, ch0_src_step, ch0_dest_step;
  logic [3:0] srcs;
  logic [7:0] count_in;
  logic [19:0] ch1_mem_address;
  logic [15:0] ch1_io_address;
  int err_count, comparisons;
  // ==========================================
  // clock, block and peripheral
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  dma_channel_alternation #(.ADDR_WIDTH(12)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_request_ch0(dreq), .ext_request_ch1(dreq),
    .serial_rx_full_0(srcs[0]), .serial_rx_full_1(srcs[1]),
    .serial_tx_empty_0(srcs[2]), .serial_tx_empty_1(srcs[3]),
    .ch0_selected_request(dreq), .ch0_end, .ch1_end, .ch0_byte_done,
    .ch0_request, .ch1_request, .ch0_bus_hold, .ch0_cpu_slot,
    .ch0_src_step, .ch0_dest_step, .ch0_mode_reserved, .ch0_is_io,
    .ch1_mem_address, .ch1_io_address);
  dma_peripheral_model peer (.aclk, .aresetn, .load, .count_in,
    .served(ch0_request), .request(dreq), .byte_done(ch0_byte_done),
    .count_end(ch0_end));
  // ==========================================
  // shared tasks
  task automatic conclude;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    begin
      comparisons++;
      if (s !== e)
      begin
        err_count++;
        $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask : chk
  // a wait that ran out is a failure in its own right
  task automatic tmo(input logic ok);
    begin
      if (ok !== 1'b1)
      begin
        err_count++;
        conclude();
      end
    end
  endtask : tmo
  // ready is a function of held state, so the negedge value is the edge's
  task automatic acc(input logic w, input logic [7:0] i,
    input logic [7:0] d, input logic [1:0] er, input logic [31:0] ed);
    int n;
    logic aw, wt, ar, got;
    logic [1:0] r;
    logic [31:0] q;
    begin
      got = 1'b0;
      // one edge on, so the last release is never assigned twice
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, i, 2'h0};
      s_axi_araddr <= {2'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 50 && !got; n++)
      begin
        @(negedge aclk);
        aw = s_axi_awvalid & s_axi_awready;
        wt = s_axi_wvalid & s_axi_wready;
        ar = s_axi_arvalid & s_axi_arready;
        got = w ? s_axi_bvalid : s_axi_rvalid;
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        @(posedge aclk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (wt) s_axi_wvalid <= 1'b0;
        if (ar) s_axi_arvalid <= 1'b0;
        if (got) s_axi_bready <= 1'b0;
        if (got) s_axi_rready <= 1'b0;
      end
      tmo(got);
      chk(r, er);
      if (!w) chk(q, ed);
    end
  endtask : acc
  task automatic ld(input logic [7:0] n);
    begin
      count_in <= n;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
    end
  endtask : ld
  // ==========================================
  // scenarios
  task automatic regs;
    int i;
    logic [7:0] v [5];
    begin
      v = '{8'h5a, 8'hc3, 8'hff, 8'h96, 8'h69};
      for (i = 0; i < 6; i++)
        acc(0, IDX_MEM_LOW + 8'(i), 8'h00, RESP_OKAY, 0);
      acc(0, IDX_CH0_MODE, 8'h00, RESP_OKAY, 0);
      acc(0, 8'h2e, 8'h00, RESP_SLVERR, 0);
      for (i = 0; i < 5; i++)
        acc(1, IDX_MEM_LOW + 8'(i), v[i], RESP_OKAY, 0);
      acc(0, IDX_MEM_BANK, 8'h00, RESP_OKAY, 32'h0f);
      chk(ch1_mem_address, 20'hfc35a);
      chk(ch1_io_address, 16'h6996);
    end
  endtask : regs
  task automatic modes;
    int m;
    begin
      for (m = 0; m < 16; m++)
      begin
        acc(1, IDX_CH0_MODE, {4'(m), 4'h0}, RESP_OKAY, 0);
        @(negedge aclk);
        chk(ch0_dest_step, m[3:2]);
        chk(ch0_src_step, m[1:0]);
        chk(ch0_mode_reserved, m[3] & m[1]);
        chk(ch0_is_io, !(m[3] & m[1])
          && (m[3:2] == 2'h3 || m[1:0] == 2'h3));
        @(posedge aclk);
      end
    end
  endtask : modes
  // pin stays high; serial patterns tell receive from transmit
  task automatic sel_test;
    int d, s, k;
    logic [3:0] p;
    logic e;
    begin
      ld(8'hff);
      for (d = 0; d < 2; d++)
      begin
        acc(1, IDX_CH0_MODE, 8'h04 | 8'(d), RESP_OKAY, 0);
        for (s = 0; s < 8; s++)
        begin
          acc(1, IDX_REQ_ALT, 8'(s), RESP_OKAY, 0);
          for (k = 0; k < 2; k++)
          begin
            p = k ? 4'hc : 4'h3;
            srcs <= p;
            @(negedge aclk);
            e = s == 0 || (s == 1 && p[d ? 0 : 2]);
            e = e || (s == 2 && p[d ? 1 : 3]);
            chk(ch1_request, e);
            @(posedge aclk);
          end
        end
      end
    end
  endtask : sel_test
  task automatic alt_test;
    int n;
    begin
      acc(1, IDX_CH0_MODE, 8'h00, RESP_OKAY, 0);
      acc(1, IDX_REQ_ALT, 8'h80, RESP_OKAY, 0);
      acc(1, IDX_CH0_MODE, 8'h3d, RESP_OKAY, 0);
      ld(8'h02);
      @(negedge aclk);
      chk(ch1_request, 1'b0);
      chk(ch0_request, 1'b1);
      for (n = 0; n < 40 && ch0_end !== 1'b1; n++)
        @(negedge aclk);
      tmo(n < 40);
      @(posedge aclk);
      acc(0, IDX_REQ_ALT, 8'h00, RESP_OKAY, 32'hc0);
      // the end dropped channel 0's enable; enable it again so that
      // only the current bit can hold its request back
      acc(1, IDX_CH0_MODE, 8'h3d, RESP_OKAY, 0);
      ld(8'h40);
      @(negedge aclk);
      chk(ch0_request, 1'b0);
      chk(ch1_request, 1'b1);
      @(posedge aclk);
      ch1_end <= 1'b1;
      @(posedge aclk);
      ch1_end <= 1'b0;
      acc(0, IDX_REQ_ALT, 8'h00, RESP_OKAY, 32'h80);
      acc(1, IDX_CH0_MODE, 8'h00, RESP_OKAY, 0);
      acc(1, IDX_REQ_ALT, 8'h40, RESP_OKAY, 0);
      acc(1, IDX_CH0_MODE, 8'h3d, RESP_OKAY, 0);
      @(negedge aclk);
      chk(ch0_request & ch1_request, 1'b1);
      @(posedge aclk);
      acc(0, IDX_REQ_ALT, 8'h00, RESP_OKAY, 32'h40);
    end
  endtask : alt_test
  // four bytes: in cycle steal three cpu slots fall before the end pulse, in burst none
  task automatic timing(input logic [7:0] m, input logic burst);
    int n, slots, gaps;
    begin
      slots = 0;
      gaps = 0;
      acc(1, IDX_CH0_MODE, m, RESP_OKAY, 0);
      ld(8'h04);
      for (n = 0; n < 60 && ch0_end !== 1'b1; n++)
      begin
        @(negedge aclk);
        slots += int'(ch0_cpu_slot);
        gaps += int'(!ch0_bus_hold);
      end
      tmo(n < 60);
      @(negedge aclk);
      chk(ch0_bus_hold, 1'b0);
      chk(slots, burst ? 0 : 3);
      // in burst only the end cycle itself lets the bus go
      if (burst) chk(gaps, 1);
      @(posedge aclk);
    end
  endtask : timing
  // ==========================================
  // main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, load, ch1_end} = 5'h00;
    {s_axi_arvalid, s_axi_rready, srcs} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, count_in} = 32'h0;
    s_axi_wdata = 32'h0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    regs();
    modes();
    sel_test();
    alt_test();
    timing(8'h0a, 1'b1);
    timing(8'h08, 1'b0);
    conclude();
  end
endmodule : tb
`default_nettype wire
